// *** hw/rate_pkg.sv ***
// Constants shared by the bit-rate and hold-timing block
//
// Overview of operation
// - Clock line is open drain: driven low or released, always sensed back.
// - Data line is open drain: driven low or released, always sensed back.
// - Own slave address lives in bits 7..1 of the address register.
// - Prescale field bits 7..6: 00 gives 1, 01 gives 2, 10 gives 4, 11 reserved.
// - Six-bit rate index in bits 5..0 sets bit rate and all hold times.
// - Index 0x00..0x1F looks up divider, data, start and stop hold counts.
// - Clock period in bus cycles equals prescale factor times divider.
// - Data changes prescale times data hold cycles after clock falls.
// - Start: clock falls prescale times start hold cycles after data falls.
// - Stop: data rises prescale times stop hold cycles after clock rises.
// - Index 0x20..0x3F uses the continued divider and hold lookup.
package rate_pkg;

   // ********************************************
   // Register map and fields
   // ********************************************
   localparam logic [7:0] OFS_ADDR = 8'h00;
   localparam logic [7:0] OFS_RATE = 8'h04;
   localparam logic [7:0] OFS_CMD  = 8'h08;
   localparam logic [7:0] OFS_STS  = 8'h0c;

   localparam logic [7:0] RST_ADDR = 8'h00;
   localparam logic [7:0] RST_RATE = 8'h00;

   localparam int ADDR_MSB = 7;
   localparam int ADDR_LSB = 1;
   localparam int PRESCALE_FACTOR_SEL_MSB = 7;
   localparam int PRESCALE_FACTOR_SEL_LSB = 6;
   localparam int ICR_MSB  = 5;
   localparam int ICR_LSB  = 0;
   localparam int CMD_MSB  = 1;
   localparam int CMD_LSB  = 0;
   localparam int CMD_DATA = 2;

   localparam int STS_BUSY = 0;
   localparam int STS_RX   = 1;
   localparam int STS_SCL  = 2;
   localparam int STS_SDA  = 3;

   // Counter width covers 4 x 3840
   localparam int CNT_W = 14;

   // Commands written to the command register
   typedef enum logic [1:0] {CMD_NONE, CMD_START, CMD_BIT, CMD_STOP} cmd_t;

   // Bit engine states
   typedef enum logic [2:0] {
      S_IDLE, S_PRE_LOW, S_PRE_HIGH, S_START,
      S_BIT_LOW, S_BIT_HIGH, S_STOP_LOW, S_STOP_HIGH
   } st_t;

   // Multiply a table count by the prescale factor; reserved code acts as one
   function automatic logic [CNT_W-1:0] scale(input logic [CNT_W-1:0] v,
                                              input logic [1:0] m);
      case (m)
         2'b01:   scale = v << 1;
         2'b10:   scale = v << 2;
         default: scale = v;
      endcase
   endfunction

endpackage

// *** hw/line_sync.sv ***
// Two-flop synchroniser for the sensed bus lines
`timescale 1ns/10ps
`default_nettype none
module line_sync (
   input  wire logic       i_clk,  // Bus clock
   input  wire logic       i_rst,  // Async reset, high
   input  wire logic [1:0] i_d,    // Raw pin levels
   output logic      [1:0] o_q     // Synchronised levels
);
   logic [1:0] meta_r;

   // Released lines idle high, so reset to high
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= 2'h3;
         o_q    <= 2'h3;
      end else begin
         meta_r <= i_d;
         o_q    <= meta_r;
      end
   end
endmodule // line_sync
`default_nettype wire

// *** hw/rate_table.sv ***
// Divider and hold count lookup indexed by the rate index
`timescale 1ns/10ps
`default_nettype none
module rate_table (
   input  wire logic [5:0]  i_idx,    // Rate index
   output logic      [11:0] o_div,    // Clock divider
   output logic      [9:0]  o_hold,   // Data hold count
   output logic      [10:0] o_start,  // Start hold count
   output logic      [10:0] o_stop    // Stop hold count
);
   logic [43:0] e;

   // Rows pack divider, data hold, start hold, stop hold
   always_comb begin
      case (i_idx)
         6'h00: e = {12'd20, 10'd7, 11'd6, 11'd11};
         6'h01: e = {12'd22, 10'd7, 11'd7, 11'd12};
         6'h02: e = {12'd24, 10'd8, 11'd8, 11'd13};
         6'h03: e = {12'd26, 10'd8, 11'd9, 11'd14};
         6'h04: e = {12'd28, 10'd9, 11'd10, 11'd15};
         6'h05: e = {12'd30, 10'd9, 11'd11, 11'd16};
         6'h06: e = {12'd34, 10'd10, 11'd13, 11'd18};
         6'h07: e = {12'd40, 10'd10, 11'd16, 11'd21};
         6'h08: e = {12'd28, 10'd7, 11'd10, 11'd15};
         6'h09: e = {12'd32, 10'd7, 11'd12, 11'd17};
         6'h0a: e = {12'd36, 10'd9, 11'd14, 11'd19};
         6'h0b: e = {12'd40, 10'd9, 11'd16, 11'd21};
         6'h0c: e = {12'd44, 10'd11, 11'd18, 11'd23};
         6'h0d: e = {12'd48, 10'd11, 11'd20, 11'd25};
         6'h0e: e = {12'd56, 10'd13, 11'd24, 11'd29};
         6'h0f: e = {12'd68, 10'd13, 11'd30, 11'd35};
         6'h10: e = {12'd48, 10'd9, 11'd18, 11'd25};
         6'h11: e = {12'd56, 10'd9, 11'd22, 11'd29};
         6'h12: e = {12'd64, 10'd13, 11'd26, 11'd33};
         6'h13: e = {12'd72, 10'd13, 11'd30, 11'd37};
         6'h14: e = {12'd80, 10'd17, 11'd34, 11'd41};
         6'h15: e = {12'd88, 10'd17, 11'd38, 11'd45};
         6'h16: e = {12'd104, 10'd21, 11'd46, 11'd53};
         6'h17: e = {12'd128, 10'd21, 11'd58, 11'd65};
         6'h18: e = {12'd80, 10'd9, 11'd38, 11'd41};
         6'h19: e = {12'd96, 10'd9, 11'd46, 11'd49};
         6'h1a: e = {12'd112, 10'd17, 11'd54, 11'd57};
         6'h1b: e = {12'd128, 10'd17, 11'd62, 11'd65};
         6'h1c: e = {12'd144, 10'd25, 11'd70, 11'd73};
         6'h1d: e = {12'd160, 10'd25, 11'd78, 11'd81};
         6'h1e: e = {12'd192, 10'd33, 11'd94, 11'd97};
         6'h1f: e = {12'd240, 10'd33, 11'd118, 11'd121};
         6'h20: e = {12'd160, 10'd17, 11'd78, 11'd81};
         6'h21: e = {12'd192, 10'd17, 11'd94, 11'd97};
         6'h22: e = {12'd224, 10'd33, 11'd110, 11'd113};
         6'h23: e = {12'd256, 10'd33, 11'd126, 11'd129};
         6'h24: e = {12'd288, 10'd49, 11'd142, 11'd145};
         6'h25: e = {12'd320, 10'd49, 11'd158, 11'd161};
         6'h26: e = {12'd384, 10'd65, 11'd190, 11'd193};
         6'h27: e = {12'd480, 10'd65, 11'd238, 11'd241};
         6'h28: e = {12'd320, 10'd33, 11'd158, 11'd161};
         6'h29: e = {12'd384, 10'd33, 11'd190, 11'd193};
         6'h2a: e = {12'd448, 10'd65, 11'd222, 11'd225};
         6'h2b: e = {12'd512, 10'd65, 11'd254, 11'd257};
         6'h2c: e = {12'd576, 10'd97, 11'd286, 11'd289};
         6'h2d: e = {12'd640, 10'd97, 11'd318, 11'd321};
         6'h2e: e = {12'd768, 10'd129, 11'd382, 11'd385};
         6'h2f: e = {12'd960, 10'd129, 11'd478, 11'd481};
         6'h30: e = {12'd640, 10'd65, 11'd318, 11'd321};
         6'h31: e = {12'd768, 10'd65, 11'd382, 11'd385};
         6'h32: e = {12'd896, 10'd129, 11'd446, 11'd449};
         6'h33: e = {12'd1024, 10'd129, 11'd510, 11'd513};
         6'h34: e = {12'd1152, 10'd193, 11'd574, 11'd577};
         6'h35: e = {12'd1280, 10'd193, 11'd638, 11'd641};
         6'h36: e = {12'd1536, 10'd257, 11'd766, 11'd769};
         6'h37: e = {12'd1920, 10'd257, 11'd958, 11'd961};
         6'h38: e = {12'd1280, 10'd129, 11'd638, 11'd641};
         6'h39: e = {12'd1536, 10'd129, 11'd766, 11'd769};
         6'h3a: e = {12'd1792, 10'd257, 11'd894, 11'd897};
         6'h3b: e = {12'd2048, 10'd257, 11'd1022, 11'd1025};
         6'h3c: e = {12'd2304, 10'd385, 11'd1150, 11'd1153};
         6'h3d: e = {12'd2560, 10'd385, 11'd1278, 11'd1281};
         6'h3e: e = {12'd3072, 10'd513, 11'd1534, 11'd1537};
         default: e = {12'd3840, 10'd513, 11'd1918, 11'd1921};
      endcase
   end

   assign o_div   = e[43:32];
   assign o_hold  = e[31:22];
   assign o_start = e[21:11];
   assign o_stop  = e[10:0];
endmodule // rate_table
`default_nettype wire

// *** hw/bit_timing.sv ***
// Bit-rate and hold-timing engine with its register slave
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module bit_timing (
   input  wire logic        i_clk,       // Bus clock, 250 MHz
   input  wire logic        i_rst,       // Async reset, high
   input  wire logic        i_wb_cyc,    // Bus cycle
   input  wire logic        i_wb_stb,    // Bus strobe
   input  wire logic        i_wb_we,     // Write enable
   input  wire logic [7:0]  i_wb_adr,    // Byte address
   input  wire logic [3:0]  i_wb_sel,    // Byte lanes
   input  wire logic [31:0] i_wb_dat,    // Write data
   output logic      [31:0] o_wb_dat,    // Read data
   output logic             o_wb_ack,    // Acknowledge
   input  wire logic        i_scl,       // Clock line level
   output logic             o_scl_o,     // Clock line drive value
   output logic             o_scl_oe,    // Clock line pulled low
   input  wire logic        i_sda,       // Data line level
   output logic             o_sda_o,     // Data line drive value
   output logic             o_sda_oe,    // Data line pulled low
   output logic      [6:0]  o_own_addr,  // Own slave address
   output logic             o_busy       // Engine busy
);
   import rate_pkg::*;

   // ********************************************
   // Registers and bus slave
   // ********************************************

   logic [7:0]       own_addr_r;
   logic [7:0]       rate_r;
   logic [7:0]       cmd_r;
   logic             pend_r;
   logic             ack_r;
   logic [31:0]      rdat_r;
   logic             req;
   logic             wr;
   logic             take;
   logic [1:0]       lines;
   logic             scl_in;
   logic             sda_in;
   st_t              state_r;
   logic [CNT_W-1:0] cnt_r;
   logic             scl_oe_r;
   logic             sda_oe_r;
   logic             rx_r;

   // New request on the bus; ack drops the cycle after it is given
   assign req = i_wb_cyc && i_wb_stb && !ack_r;
   assign wr  = req && i_wb_we && i_wb_sel[0];

   // Engine picks up a pending command only from idle
   assign take = pend_r && (state_r == S_IDLE);

   // Acknowledge one cycle after the request appears
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req;
      end
   end

   // Own address and rate settings, low lane only
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         own_addr_r <= RST_ADDR;
         rate_r     <= RST_RATE;
      end else if (wr) begin
         if (i_wb_adr == OFS_ADDR) begin
            own_addr_r <= {i_wb_dat[ADDR_MSB:ADDR_LSB], 1'b0};
         end
         if (i_wb_adr == OFS_RATE) begin
            rate_r <= i_wb_dat[7:0];
         end
      end
   end

   // Command register; a write while busy is dropped, not queued
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cmd_r  <= 8'h00;
         pend_r <= 1'b0;
      end else if (take) begin
         pend_r <= 1'b0;
      end else if (wr && i_wb_adr == OFS_CMD && !o_busy) begin
         cmd_r  <= i_wb_dat[7:0];
         pend_r <= (i_wb_dat[CMD_MSB:CMD_LSB] != CMD_NONE);
      end
   end

   // Read data captured with the ack; unmapped reads give zero
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdat_r <= 32'h0000_0000;
      end else if (req) begin
         case (i_wb_adr)
            OFS_ADDR: rdat_r <= {24'h00_0000, own_addr_r};
            OFS_RATE: rdat_r <= {24'h00_0000, rate_r};
            OFS_CMD:  rdat_r <= {24'h00_0000, cmd_r};
            OFS_STS:  rdat_r <= {28'h000_0000, sda_in, scl_in, rx_r, o_busy};
            default:  rdat_r <= 32'h0000_0000;
         endcase
      end
   end

   assign o_wb_ack   = ack_r;
   assign o_wb_dat   = rdat_r;
   assign o_own_addr = own_addr_r[ADDR_MSB:ADDR_LSB];
   assign o_busy     = pend_r || (state_r != S_IDLE);

   // ********************************************
   // Timing values
   // ********************************************

   logic [11:0]      tb_div;
   logic [9:0]       tb_hold;
   logic [10:0]      tb_start;
   logic [10:0]      tb_stop;
   logic [1:0]       mul;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] low_cyc;
   logic [CNT_W-1:0] high_cyc;
   logic [CNT_W-1:0] hold_cyc;
   logic [CNT_W-1:0] start_cyc;
   logic [CNT_W-1:0] stop_cyc;

   // Divider and hold counts from the index
   rate_table u_table (
      .i_idx   (rate_r[ICR_MSB:ICR_LSB]),
      .o_div   (tb_div),
      .o_hold  (tb_hold),
      .o_start (tb_start),
      .o_stop  (tb_stop)
   );

   assign mul = rate_r[PRESCALE_FACTOR_SEL_MSB:PRESCALE_FACTOR_SEL_LSB];

   // Every count scaled by the prescale factor
   assign period    = scale({2'b00, tb_div}, mul);
   assign hold_cyc  = scale({4'h0, tb_hold}, mul);
   assign start_cyc = scale({3'b000, tb_start}, mul);
   assign stop_cyc  = scale({3'b000, tb_stop}, mul);

   // Low half rounds down, high half takes the rest
   assign low_cyc  = period >> 1;
   assign high_cyc = period - low_cyc;

   // ********************************************
   // Bus lines
   // ********************************************

   // Sensed levels pass two flops before any use
   line_sync u_sync (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_d   ({i_scl, i_sda}),
      .o_q   (lines)
   );

   assign scl_in = lines[1];
   assign sda_in = lines[0];

   // Clock line only ever pulled low or released
   assign o_scl_o  = 1'b0;
   assign o_scl_oe = scl_oe_r;

   // Data line only ever pulled low or released
   assign o_sda_o  = 1'b0;
   assign o_sda_oe = sda_oe_r;

   // ********************************************
   // Bit engine
   // ********************************************

   // One command per run; the clock is left low after start and bit
   // so the next bit can follow without a glitch on the line.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r  <= S_IDLE;
         cnt_r    <= '0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         rx_r     <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         case (state_r)
            S_IDLE: begin
               cnt_r <= '0;
               if (take) begin
                  case (cmd_r[CMD_MSB:CMD_LSB])
                     CMD_START: begin
                        state_r <= scl_oe_r ? S_PRE_LOW : S_PRE_HIGH;
                     end
                     CMD_BIT: begin
                        state_r  <= S_BIT_LOW;
                        scl_oe_r <= 1'b1;
                     end
                     CMD_STOP: begin
                        state_r  <= S_STOP_LOW;
                        scl_oe_r <= 1'b1;
                     end
                     default: begin
                        state_r <= S_IDLE;
                     end
                  endcase
               end
            end
            // Repeated start: release data, then raise the clock
            S_PRE_LOW: begin
               if (cnt_r == hold_cyc - 1'b1) begin
                  sda_oe_r <= 1'b0;
               end
               if (cnt_r == low_cyc - 1'b1) begin
                  state_r  <= S_PRE_HIGH;
                  scl_oe_r <= 1'b0;
                  cnt_r    <= '0;
               end
            end
            // Clock high for a half period before data falls
            S_PRE_HIGH: begin
               if (!scl_in) begin
                  cnt_r <= '0;
               end else if (cnt_r == high_cyc - 1'b1) begin
                  state_r  <= S_START;
                  sda_oe_r <= 1'b1;
                  cnt_r    <= '0;
               end
            end
            // Clock held high, then falls after start hold
            S_START: begin
               if (cnt_r == start_cyc - 1'b1) begin
                  state_r  <= S_IDLE;
                  scl_oe_r <= 1'b1;
               end
            end
            // Data changes only after the data hold
            S_BIT_LOW: begin
               if (cnt_r == hold_cyc - 1'b1) begin
                  sda_oe_r <= !cmd_r[CMD_DATA];
               end
               if (cnt_r == low_cyc - 1'b1) begin
                  state_r  <= S_BIT_HIGH;
                  scl_oe_r <= 1'b0;
                  cnt_r    <= '0;
               end
            end
            // High half counts once the line is seen high (stretching)
            S_BIT_HIGH: begin
               if (!scl_in) begin
                  cnt_r <= '0;
               end else if (cnt_r == high_cyc - 1'b1) begin
                  state_r  <= S_IDLE;
                  rx_r     <= sda_in;
                  scl_oe_r <= 1'b1;
               end
            end
            // Data pulled low after the data hold
            S_STOP_LOW: begin
               if (cnt_r == hold_cyc - 1'b1) begin
                  sda_oe_r <= 1'b1;
               end
               if (cnt_r == low_cyc - 1'b1) begin
                  state_r  <= S_STOP_HIGH;
                  scl_oe_r <= 1'b0;
                  cnt_r    <= '0;
               end
            end
            // Data released after stop hold with clock high
            S_STOP_HIGH: begin
               if (!scl_in) begin
                  cnt_r <= '0;
               end else if (cnt_r == stop_cyc - 1'b1) begin
                  state_r  <= S_IDLE;
                  sda_oe_r <= 1'b0;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // ********************************************
   // Checks
   // ********************************************

   // Address field follows the written data
   chk_own_address: assert property (
      @(posedge i_clk) disable iff (i_rst)
      wr && i_wb_adr == OFS_ADDR |=> o_own_addr == $past(i_wb_dat[7:1]))
      else $error("own address not updated");

   // Prescale factor applied to the divider
   chk_mul_decode: assert property (
      @(posedge i_clk) disable iff (i_rst)
      mul == 2'b10 |-> period == {tb_div, 2'b00})
      else $error("factor four not applied");

   chk_rate_low: assert property (
      @(posedge i_clk) disable iff (i_rst)
      rate_r == 8'h07 |-> period == 14'd40 && hold_cyc == 14'd10 &&
                          start_cyc == 14'd16 && stop_cyc == 14'd21)
      else $error("index 07 lookup wrong");

   // Upper table anchors with factor two
   chk_rate_high: assert property (
      @(posedge i_clk) disable iff (i_rst)
      rate_r == 8'h7f |-> period == 14'd7680 && start_cyc == 14'd3836)
      else $error("index 3f lookup wrong");

   // Data changes in the low phase exactly at the hold count
   chk_data_hold: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $changed(sda_oe_r) && $past(state_r) == S_BIT_LOW
      |-> $past(cnt_r) == $past(hold_cyc) - 1'b1)
      else $error("data changed off the hold time");

   // Clock falls after the start hold
   chk_start_hold: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(state_r) == S_START && $rose(scl_oe_r)
      |-> $past(cnt_r) == $past(start_cyc) - 1'b1)
      else $error("start hold wrong");

   // Data rises only at the stop hold
   chk_stop_hold: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(state_r) == S_STOP_HIGH && $fell(sda_oe_r)
      |-> $past(cnt_r) == $past(stop_cyc) - 1'b1 && $past(scl_in))
      else $error("stop hold wrong");

   // Low phase lasts half the period
   chk_low_half: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(state_r) == S_BIT_LOW && $fell(scl_oe_r)
      |-> $past(cnt_r) == $past(low_cyc) - 1'b1 && state_r == S_BIT_HIGH)
      else $error("low phase length wrong");

   // Data drive is untouched while the clock is released mid-bit
   chk_sda_stable: assert property (
      @(posedge i_clk) disable iff (i_rst)
      state_r == S_BIT_HIGH && $past(state_r) == S_BIT_HIGH
      |-> $stable(sda_oe_r))
      else $error("data moved while clock high");

   // Single-cycle acknowledge
   chk_ack_pulse: assert property (
      @(posedge i_clk) disable iff (i_rst)
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held too long");

endmodule // bit_timing
`default_nettype wire

// *** tb/bus_model.sv ***
// Pull-up two-wire bus with a far device that stretches the clock and pulls data
`timescale 1ns/10ps
`default_nettype none
module bus_model (
   input  wire logic       i_clk,      // Bus clock
   input  wire logic       i_scl_oe,   // Block pulls clock low
   input  wire logic       i_sda_oe,   // Block pulls data low
   input  wire logic [3:0] i_stretch,  // Stretch length in cycles
   input  wire logic       i_sda_low,  // Far device pulls data low
   output logic            o_scl,      // Clock wire level
   output logic            o_sda       // Data wire level
);
   logic [3:0] hold_r = 4'h0;
   // Far device keeps the clock low after the block lets go, as a slow slave may
   always @(posedge i_clk) begin
      if (i_scl_oe)
         hold_r <= i_stretch;
      else if (hold_r != 4'h0)
         hold_r <= hold_r - 4'h1;
   end
   assign o_scl = !(i_scl_oe || hold_r != 4'h0);
   assign o_sda = !(i_sda_oe || i_sda_low);
endmodule // bus_model
`default_nettype wire

// *** tb/bit_timing_tb.sv ***
// Register and wire timing bench for the bit-rate and hold-timing block
`timescale 1ns/10ps
`default_nettype none
module bit_timing_tb;
   logic        clk, rst, cyc, stb, we, ack, scl, sda, scl_oe, sda_oe, busy, far_low;
   logic        scl_o, sda_o;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat;
   logic [6:0]  own;
   logic [3:0]  stretch;
   int          n_mismatch = 0;
   int          checks_done = 0;
   logic [7:0]  rt [5] = '{8'h00, 8'h47, 8'h9f, 8'h20, 8'hc0};
   int          dv [5] = '{20, 40, 240, 160, 20};
   int          hd [5] = '{7, 10, 33, 17, 7};
   int          st [5] = '{6, 16, 118, 78, 6};
   int          sp [5] = '{11, 21, 121, 81, 11};
   bit_timing uut (.i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_scl(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(sda_o),
      .o_sda_oe(sda_oe), .o_own_addr(own), .o_busy(busy));
   bus_model far (.i_clk(clk), .i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .i_stretch(stretch),
      .i_sda_low(far_low), .o_scl(scl), .o_sda(sda));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rng(input int n, input int lo, input int hi);
      check({31'h0, n >= lo && n <= hi}, 32'h1);
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: sig = scl_oe;
         1: sig = sda_oe;
         2: sig = scl;
         default: sig = busy;
      endcase
   endfunction
   // Count cycles until a watched signal reaches a level; running out ends the run
   task automatic wt(input int s, input logic v, output int n);
      n = 0;
      while (sig(s) !== v) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 20000) begin
            n_mismatch++;
            stop_test;
         end
      end
   endtask
   // Classic single cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 100);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 100) begin
         n_mismatch++;
         stop_test;
      end
   endtask
   // Start, repeated start, one stretched bit with the far device pulling data, stop
   task automatic run(input int i);
      int f, p, n, d;
      logic [31:0] q;
      f = (rt[i][7:6] == 2'b01) ? 2 : (rt[i][7:6] == 2'b10) ? 4 : 1;
      p = f * dv[i];
      wb(1'b1, 8'h04, rt[i], q);
      wb(1'b0, 8'h04, 8'h00, q);
      check(q, {24'h0, rt[i]});
      wb(1'b1, 8'h08, 8'h01, q);
      wt(1, 1'b1, n);
      wt(0, 1'b1, n);
      rng(n, f * st[i], f * st[i] + 1);
      wt(4, 1'b0, n);
      // Repeated start from a low clock: data let go at the hold, then a full period
      wb(1'b1, 8'h08, 8'h01, q);
      wt(1, 1'b0, d);
      rng(d, f * hd[i] - 1, f * hd[i] + 2);
      wt(1, 1'b1, n);
      rng(n + d, p, p + 4);
      wt(0, 1'b1, n);
      rng(n, f * st[i], f * st[i] + 1);
      wt(4, 1'b0, n);
      @(posedge clk);
      stretch <= 4'h5;
      far_low <= 1'b1;
      wb(1'b1, 8'h08, 8'h06, q);
      wt(1, 1'b0, d);
      rng(d, f * hd[i] - 1, f * hd[i] + 2);
      wt(0, 1'b0, n);
      rng(n + d, (p >> 1) - 1, (p >> 1) + 2);
      wt(2, 1'b1, n);
      wt(0, 1'b1, n);
      rng(n, p - (p >> 1), p - (p >> 1) + 4);
      wt(4, 1'b0, n);
      wb(1'b0, 8'h0c, 8'h00, q);
      check(q & 32'h2, 32'h0);
      far_low <= 1'b0;
      stretch <= 4'h0;
      wb(1'b1, 8'h08, 8'h03, q);
      wt(1, 1'b1, n);
      rng(n, f * hd[i] - 1, f * hd[i] + 2);
      wt(2, 1'b1, n);
      wt(1, 1'b0, n);
      rng(n, f * sp[i] + 1, f * sp[i] + 4);
      wt(4, 1'b0, n);
      // Synchronised line levels trail the wire by two or three cycles
      repeat (3) @(posedge clk);
      wb(1'b0, 8'h0c, 8'h00, q);
      check(q & 32'hd, 32'hc);
      check({30'h0, scl_o, sda_o}, 32'h0);
   endtask
   initial begin
      logic [31:0] q;
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      stretch = 4'h0;
      far_low = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, 8'h00, 8'h00, q);
      check(q, 32'h0);
      wb(1'b0, 8'h04, 8'h00, q);
      check(q, 32'h0);
      wb(1'b1, 8'h00, 8'ha5, q);
      wb(1'b0, 8'h00, 8'h00, q);
      check(q, 32'ha4);
      check({25'h0, own}, 32'h52);
      // Unmapped place answers but holds nothing
      wb(1'b1, 8'h10, 8'h5a, q);
      wb(1'b0, 8'h10, 8'h00, q);
      check(q, 32'h0);
      // Table anchor settings stand a few cycles each for the lookup checks
      wb(1'b1, 8'h04, 8'h07, q);
      wb(1'b1, 8'h04, 8'h7f, q);
      wb(1'b0, 8'h04, 8'h00, q);
      check(q, 32'h7f);
      for (int i = 0; i < 5; i++)
         run(i);
      stop_test;
   end
endmodule // bit_timing_tb
`default_nettype wire
